// ==== bdio_filt.sv ====
// Per-line synchroniser and stability filter for active-low field inputs.
// Assumes raw lines are asynchronous; output idles high (inactive) after reset.
`timescale 1ns/10ps
`include "bdio_regs.svh"
module bdio_filt #(
  parameter int         WIDTH = 1,
  parameter int         COUNT = 1
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] raw_i,
  output logic      [WIDTH-1:0] filt_o
);

  localparam logic [`BDIO_CNT_W-1:0] LAST = `BDIO_CNT_W'(COUNT - 1);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_line
      logic                   s1_q;
      logic                   s2_q;
      logic                   lvl_q;
      logic                   lvl_d;
      logic [`BDIO_CNT_W-1:0] cnt_q;
      logic [`BDIO_CNT_W-1:0] cnt_d;

      // Count while the synced level differs; accept only after full time
      always_comb begin
        lvl_d = lvl_q;
        cnt_d = '0;
        if (s2_q != lvl_q) begin
          if (cnt_q >= LAST) begin
            lvl_d = s2_q; // Short pulses restart the count before reaching here
          end else begin
            cnt_d = cnt_q + `BDIO_CNT_W'(1);
          end
        end
      end

      // First stage is read by the second stage only
      always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
          s1_q  <= 1'b1;
          s2_q  <= 1'b1;
          lvl_q <= 1'b1;
          cnt_q <= '0;
        end else begin
          s1_q  <= raw_i[g];
          s2_q  <= s1_q;
          lvl_q <= lvl_d;
          cnt_q <= cnt_d;
        end
      end

      assign filt_o[g] = lvl_q;
    end
  endgenerate

endmodule

// ==== bdio_host.sv ====
// Board processor model: AHB-Lite master issuing single word transfers.
// Assumes one slave whose hreadyout is looped back as hready.
`timescale 1ns/10ps
module bdio_host (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o,
  output logic             hung_o
);
  // Bus idle at time zero; whole words only
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h00000000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h00000000;
    hung_o   = 1'b0;
  end

  // Waits for hready at a rising edge; a dead slave raises hung_o
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hready_i !== 1'b1 && n < 16);
    if (hready_i !== 1'b1) hung_o = 1'b1;
  endtask

  // One transfer; caller enters just after an edge. Input buffers are
  // fetched by separate reads, one register per call
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel_o   <= 1'b1;
    haddr_o  <= {24'h000000, a};
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    wait_rdy();
    htrans_o <= 2'h0;
    hwdata_o <= d;
    wait_rdy();
    q = hrdata_i;
  endtask
endmodule

// ==== bdio_pkg.sv ====
// Types shared by the breaker discrete I/O channel block.
// Assumes the constants header is included by the users of these types.
package bdio_pkg;

  // High input buffer image, all bits active low
  typedef struct packed {
    logic       hold1_n;
    logic       hold0_n;
    logic       supply1_n;
    logic       supply0_n;
    logic       coil1_n;
    logic       coil0_n;
    logic [2:0] gen_hi_n;
  } bdio_high_t;

  // Indicator group driven to the front panel
  typedef struct packed {
    logic [10:0] gen;
    logic [1:0]  supply;
    logic [1:0]  coil;
    logic [1:0]  hold;
    logic [1:0]  drive;
    logic        link_sel;
    logic        tx;
    logic        rx;
    logic        wdog;
  } bdio_led_t;

  typedef enum logic [0:0] {
    BDIO_BUS_IDLE  = 1'b0,
    BDIO_BUS_WDATA = 1'b1
  } bdio_bus_st_t;

endpackage

// ==== bdio_regs.svh ====
// Register offsets, field positions, reset values and timing counts for the
// breaker discrete I/O channel block. Assumes byte addresses on a 32-bit AHB-Lite bus.
// What this block does
// - Logic runs on one board clock; every timing count derives from it.
// - One output latch holds two active-low drives, one per solenoid channel.
// - With drive off, coil test applies; coil-ready asserts when coil conducts.
// - Open coil circuit keeps that channel's coil-ready status inactive.
// - Inputs read as two buffers; low byte holds general inputs 1-8.
// - High buffer holds inputs 9-11, coil-ready, power-present, seal-in flags.
// - Three excitation sense lines read directly, outside both input buffers.
// - General inputs ignore pulses shorter than 10 ms.
// - Active input reads low and lights its indicator while active.
// - Excitation sense lines filtered and active-low like inputs, no indicator.
// - Power-present status asserts with supply present and lights its indicator.
// - Coil-ready indicator lit whenever coil-ready status is asserted.
// - On link timeout with seal-in active, output stays energized.
// - Seal-in holds output only with its switch set and supply present.
// - Seal-in indicator lit while switch enabled and seal-in voltage present.
// - Output indicator lit while that channel's drive is enabled.
// - Processor port outputs act as chip enables for buffers and latch.
// - Link-select indicator lit for receive on port A, dark for port B.
// - Transmit and receive indicators flash with link traffic.
// - Watchdog indicator lit while the watchdog is being retriggered.
// - Calibration jumper fitted suppresses NMI; removed, a latch drives NMI high.
// - On link timeout, channels without seal-in have their latch bit cleared.
// - While output on, reported coil status forced true; real status when off.
// - Command bit 0 drives channel 0, bit 1 drives channel 1; bits 2-3 coil test; others unused.
// - All excitation lines absent: images frozen, voltage-off error flag set.
`ifndef BDIO_REGS_SVH
`define BDIO_REGS_SVH

// Register byte offsets
`define BDIO_OFS_LATCH   8'h00
`define BDIO_OFS_IN_LO   8'h04
`define BDIO_OFS_IN_HI   8'h08
`define BDIO_OFS_SENSE   8'h0C
`define BDIO_OFS_CTRL    8'h10

// Latch fields
`define BDIO_LATCH_DRV0  0
`define BDIO_LATCH_DRV1  1
`define BDIO_LATCH_TST0  2
`define BDIO_LATCH_TST1  3
`define BDIO_LATCH_RST   4'h0

// Sense register fields
`define BDIO_SENSE_ERR   3

// Control register fields
`define BDIO_CTRL_PORTA  0
`define BDIO_CTRL_KICK   1
`define BDIO_CTRL_TX     2
`define BDIO_CTRL_RX     3
`define BDIO_CTRL_TMO    4

// Timing
`define BDIO_CLK_HZ      125000000
`define BDIO_FILT_MS     10
`define BDIO_WDOG_MS     1
`define BDIO_FLASH_MS    20
`define BDIO_CNT_W       22

`endif

// ==== bdio_top.sv ====
// Breaker discrete I/O channel controller: output latch, coil test, input
// images, seal-in failsafe and indicators behind an AHB-Lite register slave.
// Assumes one 125 MHz clock, zero-wait single word transfers, field pins async.
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "bdio_regs.svh"
module bdio_top
  import bdio_pkg::*;
#(
  parameter int FILT_CYC  = `BDIO_CLK_HZ / 1000 * `BDIO_FILT_MS, // One clock times all
  parameter int WDOG_CYC  = `BDIO_CLK_HZ / 1000 * `BDIO_WDOG_MS,
  parameter int FLASH_CYC = `BDIO_CLK_HZ / 1000 * `BDIO_FLASH_MS
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Field inputs, active low unless named otherwise
  input  wire logic [10:0] gen_input_n_i,
  input  wire logic [2:0]  excite_sense_n_i,
  input  wire logic [1:0]  coil_current_n_i,
  input  wire logic [1:0]  supply_present_n_i,
  input  wire logic [1:0]  hold_supply_n_i,
  input  wire logic [1:0]  hold_enable_sw_i,
  input  wire logic        cal_jumper_i,
  // Channel outputs
  output logic             drive0_n_o,
  output logic             drive1_n_o,
  output logic [1:0]       coil_test_o,
  output logic             nmi_o,
  output logic             sel_in_lo_o,
  output logic             sel_in_hi_o,
  output logic             sel_latch_o,
  output bdio_led_t        led_o
);

  localparam logic [`BDIO_CNT_W-1:0] WDOG_LAST  = `BDIO_CNT_W'(WDOG_CYC - 1);
  localparam logic [`BDIO_CNT_W-1:0] FLASH_LAST = `BDIO_CNT_W'(FLASH_CYC - 1);
  // Blink bit follows the stretch length, so short counts still flash
  localparam int                     BLINK      = $clog2(FLASH_CYC) - 3;

  // Filtered and synchronised field lines
  logic [13:0] slow_filt;
  logic [7:0]  fast_filt;
  logic [10:0] gen_f;
  logic [2:0]  sense_f;
  logic [1:0]  coil_f;
  logic [1:0]  supply_f;
  logic [1:0]  hsup_f;
  logic [1:0]  hsw_f;
  logic        jumper_f;

  // General inputs and excitation lines share the long filter
  bdio_filt #(.WIDTH(14), .COUNT(FILT_CYC)) u_slow (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .raw_i  ({excite_sense_n_i, gen_input_n_i}),
    .filt_o (slow_filt)
  );

  // Status lines only need synchronising; a one-cycle count passes them through
  bdio_filt #(.WIDTH(9), .COUNT(1)) u_fast (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .raw_i  ({cal_jumper_i, ~hold_enable_sw_i, hold_supply_n_i,
              supply_present_n_i, coil_current_n_i}),
    .filt_o ({jumper_f, fast_filt})
  );

  assign gen_f    = slow_filt[10:0];
  assign sense_f  = slow_filt[13:11];
  assign coil_f   = fast_filt[1:0];
  assign supply_f = fast_filt[3:2];
  assign hsup_f   = fast_filt[5:4];
  assign hsw_f    = ~fast_filt[7:6];

  // Bus state
  bdio_bus_st_t st_q;
  bdio_bus_st_t st_d;
  logic [7:0]   waddr_q;
  logic [7:0]   waddr_d;
  logic [31:0]  rdata_q;
  logic [31:0]  rdata_d;
  logic [2:0]   sel_q;
  logic [2:0]   sel_d;

  // Channel state
  logic [3:0]   latch_q;
  logic [3:0]   latch_d;
  logic         porta_q;
  logic         porta_d;
  logic         err_q;
  logic         err_d;
  logic [7:0]   img_lo_q;
  logic [7:0]   img_lo_d;
  bdio_high_t   img_hi_q;
  bdio_high_t   img_hi_d;
  logic         nmi_q;
  logic         nmi_d;
  logic [1:0]   test_q;
  logic [1:0]   test_d;
  bdio_led_t    led_q;
  bdio_led_t    led_d;
  logic [`BDIO_CNT_W-1:0] wdog_q;
  logic [`BDIO_CNT_W-1:0] wdog_d;
  logic [`BDIO_CNT_W-1:0] tx_q;
  logic [`BDIO_CNT_W-1:0] tx_d;
  logic [`BDIO_CNT_W-1:0] rx_q;
  logic [`BDIO_CNT_W-1:0] rx_d;

  // Live status values
  logic        addr_ok;
  logic        wr_ctrl;
  logic        wr_latch;
  logic        wr_sense;
  logic [1:0]  drive_on;
  logic [1:0]  hold_on;
  logic [1:0]  coil_rdy_n;
  logic        sense_lost;

  // Seal-in is active only with its switch set and supply present
  assign hold_on  = hsw_f & ~hsup_f;
  assign drive_on = latch_q[1:0];

  // Coil conducts only while test applied with drive off; open coil stays high
  // An energized channel reports coil true to avoid false alarms
  assign coil_rdy_n = ~((test_q & coil_f ^ test_q) | drive_on);

  // All three lines absent means no interrogation voltage
  assign sense_lost = &sense_f;

  assign addr_ok  = hsel_i && htrans_i[1] && hready_i;
  assign wr_latch = (st_q == BDIO_BUS_WDATA) && (waddr_q == `BDIO_OFS_LATCH);
  assign wr_sense = (st_q == BDIO_BUS_WDATA) && (waddr_q == `BDIO_OFS_SENSE);
  assign wr_ctrl  = (st_q == BDIO_BUS_WDATA) && (waddr_q == `BDIO_OFS_CTRL);

  // Read mux over the register map; unmapped words read zero
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == `BDIO_OFS_LATCH) begin
      r[3:0] = latch_q;
    end else if (a == `BDIO_OFS_IN_LO) begin
      r[7:0] = img_lo_q; // Low buffer: inputs 1-8
    end else if (a == `BDIO_OFS_IN_HI) begin
      r[8:0] = img_hi_q; // High buffer: remaining nine flags
    end else if (a == `BDIO_OFS_SENSE) begin
      r[2:0] = sense_f;  // Direct excitation lines, not in the buffers
      r[`BDIO_SENSE_ERR] = err_q;
    end else if (a == `BDIO_OFS_CTRL) begin
      r[`BDIO_CTRL_PORTA] = porta_q;
    end
    return r;
  endfunction

  // Chip-enable decode, shared by the select pulses
  function automatic logic [2:0] ce_dec(input logic [7:0] a);
    logic [2:0] c;
    c = 3'h0;
    if (a == `BDIO_OFS_IN_LO) begin
      c = 3'h1;
    end else if (a == `BDIO_OFS_IN_HI) begin
      c = 3'h2;
    end else if (a == `BDIO_OFS_LATCH) begin
      c = 3'h4;
    end
    return c;
  endfunction

  // Bus slave: address phase captured, writes applied in the data phase.
  // Read data is taken at the address edge so every answer is zero-wait.
  always_comb begin
    st_d    = BDIO_BUS_IDLE;
    waddr_d = waddr_q;
    rdata_d = rdata_q;
    sel_d   = 3'h0;
    if (addr_ok) begin
      waddr_d = haddr_i[7:0];
      sel_d   = ce_dec(haddr_i[7:0]); // Select pulse per buffer or latch access
      if (hwrite_i) begin
        st_d = BDIO_BUS_WDATA;
      end else begin
        rdata_d = rd_mux(haddr_i[7:0]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q    <= BDIO_BUS_IDLE;
      waddr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      sel_q   <= 3'h0;
    end else begin
      st_q    <= st_d;
      waddr_q <= waddr_d;
      rdata_q <= rdata_d;
      sel_q   <= sel_d;
    end
  end

  // Latch, images, error flag and control bits
  always_comb begin
    latch_d  = latch_q;
    porta_d  = porta_q;
    err_d    = err_q;
    img_lo_d = img_lo_q;
    img_hi_d = img_hi_q;
    if (wr_latch) begin
      latch_d = hwdata_i[3:0]; // Bit 0 channel 0, bit 1 channel 1
    end
    if (wr_ctrl) begin
      porta_d = hwdata_i[`BDIO_CTRL_PORTA];
      if (hwdata_i[`BDIO_CTRL_TMO]) begin
        // Timeout: keep sealed-in channels, drop the rest
        latch_d[1:0] = latch_d[1:0] & hold_on;
      end
    end
    // Error clears by writing one; a new loss in the same cycle wins
    if (wr_sense && hwdata_i[`BDIO_SENSE_ERR]) begin
      err_d = 1'b0;
    end
    if (sense_lost) begin
      err_d = 1'b1;
    end else begin
      // Images refresh only with interrogation voltage present
      img_lo_d = gen_f[7:0]; // Active input reads low
      img_hi_d.gen_hi_n = gen_f[10:8];
      img_hi_d.coil0_n  = coil_rdy_n[0];
      img_hi_d.coil1_n  = coil_rdy_n[1];
      img_hi_d.supply0_n = supply_f[0];
      img_hi_d.supply1_n = supply_f[1];
      img_hi_d.hold0_n  = ~hold_on[0];
      img_hi_d.hold1_n  = ~hold_on[1];
    end
  end

  // Reset leaves both drives and both coil tests off
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      latch_q  <= `BDIO_LATCH_RST;
      porta_q  <= 1'b0;
      err_q    <= 1'b0;
      img_lo_q <= 8'hFF;
      img_hi_q <= 9'h1FF;
    end else begin
      latch_q  <= latch_d;
      porta_q  <= porta_d;
      err_q    <= err_d;
      img_lo_q <= img_lo_d;
      img_hi_q <= img_hi_d;
    end
  end

  // Activity stretchers: watchdog kick and link traffic pulses
  always_comb begin
    wdog_d = (wdog_q != '0) ? wdog_q - `BDIO_CNT_W'(1) : wdog_q;
    tx_d   = (tx_q != '0) ? tx_q - `BDIO_CNT_W'(1) : tx_q;
    rx_d   = (rx_q != '0) ? rx_q - `BDIO_CNT_W'(1) : rx_q;
    if (wr_ctrl && hwdata_i[`BDIO_CTRL_KICK]) begin
      wdog_d = WDOG_LAST; // Lit while kicks keep arriving
    end
    if (wr_ctrl && hwdata_i[`BDIO_CTRL_TX]) begin
      tx_d = FLASH_LAST;
    end
    if (wr_ctrl && hwdata_i[`BDIO_CTRL_RX]) begin
      rx_d = FLASH_LAST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wdog_q <= '0;
      tx_q   <= '0;
      rx_q   <= '0;
    end else begin
      wdog_q <= wdog_d;
      tx_q   <= tx_d;
      rx_q   <= rx_d;
    end
  end

  // Output flops: coil test, NMI latch and indicators
  always_comb begin
    // Test never applied to an energized channel, whatever software asks
    // Taken from the next latch value so test and drive switch on one edge
    test_d = latch_d[`BDIO_LATCH_TST1:`BDIO_LATCH_TST0] & ~latch_d[1:0];
    // Fitted jumper reads high here and holds NMI low
    nmi_d  = jumper_f ? 1'b0 : 1'b1;
    led_d.gen      = ~gen_f;       // Lit while input active
    led_d.supply   = ~supply_f;
    led_d.coil     = ~coil_rdy_n;
    led_d.hold     = hold_on;
    led_d.drive    = drive_on;
    led_d.link_sel = porta_q;
    led_d.tx       = (tx_q != '0) && tx_q[BLINK];
    led_d.rx       = (rx_q != '0) && rx_q[BLINK];
    led_d.wdog     = (wdog_q != '0);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      test_q <= 2'h0;
      nmi_q  <= 1'b0;
      led_q  <= '0;
    end else begin
      test_q <= test_d;
      nmi_q  <= nmi_d;
      led_q  <= led_d;
    end
  end

  // Drives are the inverted latch bits, so a set bit pulls the line low
  logic [1:0] drv_n_q;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      drv_n_q <= 2'h3;
    end else begin
      drv_n_q <= ~latch_d[1:0];
    end
  end

  // Response is always OKAY and the slave never stalls
  logic ready_q;
  logic resp_q;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end else begin
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end
  end

  assign hrdata_o    = rdata_q;
  assign hreadyout_o = ready_q;
  assign hresp_o     = resp_q;
  assign drive0_n_o  = drv_n_q[0];
  assign drive1_n_o  = drv_n_q[1];
  assign coil_test_o = test_q;
  assign nmi_o       = nmi_q;
  assign sel_in_lo_o = sel_q[0];
  assign sel_in_hi_o = sel_q[1];
  assign sel_latch_o = sel_q[2];
  assign led_o       = led_q;

endmodule

// ==== bdio_top_monitor.sv ====
// Concurrent checks on the breaker discrete I/O block, seen from its ports.
// Assumes one clock and the synchronous active-low reset of the top module.
`timescale 1ns/10ps
`include "bdio_regs.svh"
module bdio_top_monitor
  import bdio_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hready_i,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic [1:0]  supply_present_n_i,
  input  wire logic [1:0]  hold_supply_n_i,
  input  wire logic [1:0]  hold_enable_sw_i,
  input  wire logic        cal_jumper_i,
  input  wire logic        drive0_n_o,
  input  wire logic        drive1_n_o,
  input  wire logic [1:0]  coil_test_o,
  input  wire logic        nmi_o,
  input  wire logic        sel_in_lo_o,
  input  wire logic        sel_in_hi_o,
  input  wire logic        sel_latch_o,
  input  wire bdio_led_t   led_o
);
  logic acc;

  // Address phase taken by the slave
  assign acc = hsel_i & htrans_i[1] & hready_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  chk_latch_select: assert property (
    acc && haddr_i[7:0] == `BDIO_OFS_LATCH |=> sel_latch_o && !sel_in_lo_o && !sel_in_hi_o)
    else $error("latch select missing");
  chk_sel_cause: assert property (
    (sel_in_lo_o || sel_in_hi_o || sel_latch_o) |-> $past(acc))
    else $error("select without access");
  chk_drive_led: assert property (
    led_o.drive == $past({~drive1_n_o, ~drive0_n_o}))
    else $error("drive indicator wrong");
  chk_test_interlock: assert property (
    !(coil_test_o[0] && !drive0_n_o) && !(coil_test_o[1] && !drive1_n_o))
    else $error("coil test with drive on");
  chk_nmi_fitted: assert property (cal_jumper_i [*5] |=> !nmi_o)
    else $error("nmi with jumper fitted");
  chk_nmi_removed: assert property (!cal_jumper_i [*5] |=> nmi_o)
    else $error("nmi low with jumper removed");
  chk_supply_led: assert property (!supply_present_n_i[0] [*5] |=> led_o.supply[0])
    else $error("supply indicator dark");
  chk_hold_on: assert property (
    (hold_enable_sw_i[0] && !hold_supply_n_i[0]) [*5] |=> led_o.hold[0])
    else $error("hold indicator dark");
  chk_hold_off: assert property (
    (!hold_enable_sw_i[1] || hold_supply_n_i[1]) [*5] |=> !led_o.hold[1])
    else $error("hold indicator lit");
  chk_reset_safe: assert property (
    $rose(nrst_i) |-> drive0_n_o && drive1_n_o && coil_test_o == 2'h0)
    else $error("output live after reset");

  // Main scenarios reached
  cov_both_on: cover property (!drive0_n_o && !drive1_n_o);
  cov_coil_test: cover property (coil_test_o[0]);
  cov_wdog: cover property (led_o.wdog);
endmodule

bind bdio_top bdio_top_monitor u_mon (
  .clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hready_i, .hreadyout_o, .hresp_o,
  .supply_present_n_i, .hold_supply_n_i, .hold_enable_sw_i, .cal_jumper_i,
  .drive0_n_o, .drive1_n_o, .coil_test_o, .nmi_o, .sel_in_lo_o, .sel_in_hi_o,
  .sel_latch_o, .led_o
);

// ==== tb_breaker_dio_channel_controller.sv ====
// Self-checking bench for the breaker discrete I/O block.
// Assumes the host model as bus master and short filter and timer counts.
`timescale 1ns/10ps
`include "bdio_regs.svh"
module tb_breaker_dio_channel_controller
  import bdio_pkg::*;
;
  logic        clk_i, nrst_i, hsel, hwrite, hready, hresp, jumper, hung;
  logic        drv0_n, drv1_n, nmi;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, coil_n, sup_n, hsup_n, hsw, ctest;
  logic [2:0]  hsize, sense_n;
  logic [10:0] gen_n;
  bdio_led_t   led;
  int          fails, checks;

  bdio_top #(.FILT_CYC(8), .WDOG_CYC(16), .FLASH_CYC(64)) u_dut (
    .clk_i, .nrst_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .gen_input_n_i(gen_n), .excite_sense_n_i(sense_n),
    .coil_current_n_i(coil_n), .supply_present_n_i(sup_n), .hold_supply_n_i(hsup_n),
    .hold_enable_sw_i(hsw), .cal_jumper_i(jumper), .drive0_n_o(drv0_n), .drive1_n_o(drv1_n),
    .coil_test_o(ctest), .nmi_o(nmi), .sel_in_lo_o(), .sel_in_hi_o(), .sel_latch_o(),
    .led_o(led));

  bdio_host u_host (
    .clk_i, .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata), .hung_o(hung));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    u_host.xfer(1'b0, a, 32'h00000000, q);
  endtask

  task automatic final_report();
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Outputs safe straight after reset, idle low input image inactive
  task automatic t_reset();
    logic [31:0] q;
    chk(32'({drv1_n, drv0_n, ctest}), 32'h0000000C);
    rd(`BDIO_OFS_LATCH, q);
    chk(q, 32'h00000000);
    tick(20);
    rd(`BDIO_OFS_IN_LO, q);
    chk(q, 32'h000000FF);
  endtask

  // Filtered images, indicators, short pulse rejected
  task automatic t_inputs();
    logic [31:0] q;
    gen_n <= 11'h2A5;
    tick(20);
    rd(`BDIO_OFS_IN_LO, q);
    chk(q, 32'h000000A5);
    rd(`BDIO_OFS_IN_HI, q);
    chk(q, 32'h000001FA);
    chk(32'(led.gen), 32'h0000055A);
    gen_n <= 11'h7FF;
    tick(4);
    gen_n <= 11'h2A5;
    tick(20);
    rd(`BDIO_OFS_IN_LO, q);
    chk(q, 32'h000000A5);
    gen_n <= 11'h7FF;
    tick(20);
    rd(`BDIO_OFS_IN_LO, q);
    chk(q, 32'h000000FF);
  endtask

  // Sense lines read directly; all absent freezes images and flags error
  task automatic t_sense();
    logic [31:0] q;
    sense_n <= 3'h5;
    tick(20);
    wr(`BDIO_OFS_SENSE, 32'h00000008);
    tick(1);
    rd(`BDIO_OFS_SENSE, q);
    chk(q, 32'h00000005);
    sense_n <= 3'h7;
    tick(20);
    gen_n <= 11'h000;
    tick(20);
    rd(`BDIO_OFS_SENSE, q);
    chk(q, 32'h0000000F);
    rd(`BDIO_OFS_IN_LO, q);
    chk(q, 32'h000000FF);
    sense_n <= 3'h0;
    tick(20);
    rd(`BDIO_OFS_IN_LO, q);
    chk(q, 32'h00000000);
    wr(`BDIO_OFS_SENSE, 32'h00000008);
    tick(1);
    rd(`BDIO_OFS_SENSE, q);
    chk(q, 32'h00000000);
    gen_n <= 11'h7FF;
  endtask

  // Every drive code, then unused command bits ignored
  task automatic t_drive();
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      wr(`BDIO_OFS_LATCH, 32'(i));
      tick(3);
      chk(32'({drv1_n, drv0_n}), 32'(~i & 3));
      chk(32'(led.drive), 32'(i));
    end
    wr(`BDIO_OFS_LATCH, 32'hFFFFFF33);
    tick(1);
    rd(`BDIO_OFS_LATCH, q);
    chk(q, 32'h00000003);
    wr(`BDIO_OFS_LATCH, 32'h00000000);
  endtask

  // Coil test with the drive off only forced status with drive on
  task automatic t_coil();
    logic [31:0] q;
    wr(`BDIO_OFS_LATCH, 32'h00000004);
    coil_n <= 2'h2;
    tick(6);
    chk(32'(ctest), 32'h00000001);
    rd(`BDIO_OFS_IN_HI, q);
    chk(32'(q[4:3]), 32'h00000002);
    chk(32'(led.coil), 32'h00000001);
    coil_n <= 2'h3;
    tick(6);
    rd(`BDIO_OFS_IN_HI, q);
    chk(32'(q[4:3]), 32'h00000003);
    wr(`BDIO_OFS_LATCH, 32'h00000001);
    tick(3);
    chk(32'(ctest), 32'h00000000);
    rd(`BDIO_OFS_IN_HI, q);
    chk(32'(q[4:3]), 32'h00000002);
    wr(`BDIO_OFS_LATCH, 32'h00000000);
  endtask

  // Seal-in on ch0 only; ch1 switch set but no supply; link timeout
  task automatic t_hold();
    logic [31:0] q;
    hsw <= 2'h3;
    hsup_n <= 2'h2;
    sup_n <= 2'h2;
    wr(`BDIO_OFS_LATCH, 32'h00000003);
    tick(6);
    rd(`BDIO_OFS_IN_HI, q);
    chk(32'(q[8:5]), 32'h0000000A);
    chk(32'({led.hold, led.supply}), 32'h00000005);
    wr(`BDIO_OFS_CTRL, 32'h00000010);
    tick(3);
    chk(32'({drv1_n, drv0_n}), 32'h00000002);
    rd(`BDIO_OFS_LATCH, q);
    chk(q, 32'h00000001);
    hsw <= 2'h0;
    hsup_n <= 2'h3;
    sup_n <= 2'h3;
    wr(`BDIO_OFS_LATCH, 32'h00000000);
  endtask

  // Link select, watchdog indicator, unmapped read, calibration jumper
  task automatic t_misc();
    logic [31:0] q;
    wr(`BDIO_OFS_CTRL, 32'h00000001);
    tick(3);
    chk(32'(led.link_sel), 32'h00000001);
    wr(`BDIO_OFS_CTRL, 32'h00000002);
    tick(3);
    chk(32'({led.link_sel, led.wdog}), 32'h00000001);
    tick(40);
    chk(32'(led.wdog), 32'h00000000);
    wr(`BDIO_OFS_CTRL, 32'h0000000C);
    tick(3);
    chk(32'({led.tx, led.rx}), 32'h00000003);
    tick(7);
    chk(32'({led.tx, led.rx}), 32'h00000000);
    tick(63);
    chk(32'({led.tx, led.rx}), 32'h00000000);
    rd(8'h20, q);
    chk(q, 32'h00000000);
    jumper <= 1'b0;
    tick(8);
    chk(32'(nmi), 32'h00000001);
    jumper <= 1'b1;
    tick(8);
    chk(32'(nmi), 32'h00000000);
  endtask

  // Free-running 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Reset, then the scenarios in turn
  initial begin
    fails = 0;
    checks = 0;
    nrst_i = 1'b0;
    gen_n = 11'h7FF;
    sense_n = 3'h0;
    coil_n = 2'h3;
    sup_n = 2'h3;
    hsup_n = 2'h3;
    hsw = 2'h0;
    jumper = 1'b1;
    tick(8);
    nrst_i <= 1'b1;
    tick(1);
    t_reset();
    t_inputs();
    t_sense();
    t_drive();
    t_coil();
    t_hold();
    t_misc();
    final_report();
  end

  // A bus wait that ran out ends the run as a failure
  always @(posedge hung) begin
    fails++;
    final_report();
  end
endmodule
